// File: fieldbus_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module fieldbus_master_model
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // command to send
  input wire logic [7:0] next_cmd,
  // cyclic frame
  output logic [7:0] command_byte,
  output logic data_valid
);
  // one whole byte per frame, inverted between frames
  always @(posedge clk_sys or posedge reset)
    if (reset)
    begin
      command_byte <= 8'h00;
      data_valid <= 1'b0;
    end
    else
    begin
      data_valid <= #1 !data_valid;
      command_byte <= #1 data_valid ? ~next_cmd : next_cmd;
    end
endmodule
`default_nettype wire

// File: hours_counter.sv
`timescale 1ns/1ns
`default_nettype none
`include "laser_cmd_cfg.svh"
module hours_counter
  import laser_cmd_pkg::*;
#(
  parameter logic [39:0] CYCLES_PER_HOUR = 40'(`CYCLES_PER_HOUR)
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // counting
  input wire logic laser_on,
  output logic [15:0] hours
);
  typedef struct packed {
    logic [39:0] tick;
    logic [15:0] hours;
  } hours_state_t;

  hours_state_t state_reg;
  hours_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    if (laser_on)
    begin
      if (state_reg.tick == CYCLES_PER_HOUR - 40'h1)
      begin
        state_next.tick = 40'h0;
        // saturate rather than wrap
        if (state_reg.hours != 16'hFFFF)
          state_next.hours = state_reg.hours + 16'h1;
      end
      else
        state_next.tick = state_reg.tick + 40'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign hours = state_reg.hours;
endmodule
`default_nettype wire

// File: laser_cmd_cfg.svh
`ifndef LASER_CMD_CFG_SVH
`define LASER_CMD_CFG_SVH

// command and acknowledge bit positions (same in both bytes)
`define BIT_LASER_OFF 0
`define BIT_LASER_ON 1
`define BIT_ADJUST 4
`define BIT_PRESET 5
`define BIT_PRESET_CLR 6
`define BIT_ERR_CLR 7
// bits that carry a function; bits 2 and 3 unused
`define CMD_USED_MASK 8'hF3
// configuration identifiers
`define CFG_ID_CMD_ACK 8'h30
`define CFG_ID_HOURS 8'hD0
// error clear policy values and reset
`define POLICY_MANUAL 8'h00
`define POLICY_AUTO 8'h01
`define POLICY_RESET 8'h00
// laser switching source values
`define LSW_COMMAND 2'h0
`define LSW_EXT_INPUT 2'h1
`define LSW_AUTO 2'h2
// operating hours: one hour at 25 MHz
`define CLK_HZ 25000000
`define SECONDS_PER_HOUR 3600
`define CYCLES_PER_HOUR (`CLK_HZ * 64'd`SECONDS_PER_HOUR)

`endif

// File: laser_cmd_pkg.sv
package laser_cmd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_HOLD = 3'b100
  } cmd_state_t;
endpackage

// File: laser_command_ack_unit.sv
`timescale 1ns/1ns
`default_nettype none
`include "laser_cmd_cfg.svh"
// Notes on behaviour
// - command bit 0 switches laser off
// - command bit 1 switches laser on
// - bit 5 loads position with stored preset
// - manual mode: bit 7 clears error report
// - persisting error sets report again next cycle
// - acknowledge executed command in same bit
// - bitwise, 1 active, bits 2,3 unused
// - one byte each way, identifier 0x30
// - policy 0 manual clear, 1 automatic
// - report laser hours as 16-bit word
module laser_command_ack_unit
  import laser_cmd_pkg::*;
#(
  parameter logic [39:0] CYCLES_PER_HOUR = 40'(`CYCLES_PER_HOUR)
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // cyclic process data from master
  input wire logic [7:0] command_byte,
  input wire logic [31:0] adjust_value,
  input wire logic data_valid,
  // parameterisation
  input wire logic [7:0] error_clear_policy,
  input wire logic prm_write,
  input wire logic [1:0] laser_switch_mode,
  input wire logic [31:0] preset_value,
  input wire logic external_laser_switch_input,
  input wire logic auto_laser_request,
  // measurement
  input wire logic [31:0] raw_position,
  input wire logic fault_present,
  // process data to master
  output logic [7:0] acknowledge_byte,
  output logic [15:0] laser_hours_word,
  output logic [7:0] cfg_id_cmd_ack,
  output logic [7:0] cfg_id_hours,
  // device outputs
  output logic laser_enable,
  output logic [31:0] position_out,
  output logic error_report
);
  typedef struct packed {
    cmd_state_t state;
    logic [7:0] cmd_prev;
    logic [7:0] ack;
    logic [7:0] policy;
    logic laser_cmd;
    logic laser_en;
    logic [31:0] offset;
    logic [31:0] position;
    logic error;
    logic [15:0] hours;
  } unit_state_t;

  unit_state_t state_reg;
  unit_state_t state_next;
  logic [15:0] hours_count;
  logic [7:0] cmd_used;
  logic [7:0] rise;

  // ----------------------------------------
  // operating hours of the lit laser
  // ----------------------------------------
  // hours counter
  hours_counter #(
    .CYCLES_PER_HOUR(CYCLES_PER_HOUR)
  ) u_hours (
    .clk_sys(clk_sys),
    .reset(reset),
    .laser_on(state_reg.laser_en),
    .hours(hours_count)
  );

  // ----------------------------------------
  // command interpretation
  // ----------------------------------------
  always_comb
  begin
    cmd_used = command_byte & `CMD_USED_MASK;
    rise = cmd_used & ~state_reg.cmd_prev;
    state_next = state_reg;
    state_next.hours = hours_count;
    if (prm_write)
      state_next.policy = error_clear_policy;
    case (state_reg.state)
      ST_IDLE:
      begin
        if (data_valid && (rise != 8'h00))
          state_next.state = ST_EXEC;
      end
      ST_EXEC:
      begin
        state_next.state = ST_HOLD;
      end
      ST_HOLD:
      begin
        if (cmd_used == 8'h00)
          state_next.state = ST_IDLE;
      end
      default:
      begin
        state_next.state = ST_IDLE;
      end
    endcase
    if (data_valid)
    begin
      state_next.cmd_prev = cmd_used;
      if (laser_switch_mode == `LSW_COMMAND)
      begin
        if (rise[`BIT_LASER_OFF])
          state_next.laser_cmd = 1'b0;
        else if (rise[`BIT_LASER_ON])
          state_next.laser_cmd = 1'b1;
      end
      if (rise[`BIT_PRESET])
        state_next.offset = preset_value - raw_position;
      if (rise[`BIT_ADJUST])
        state_next.offset = adjust_value - raw_position;
      if (rise[`BIT_PRESET_CLR])
        state_next.offset = 32'h0;
      state_next.ack = state_reg.ack & cmd_used;
      state_next.ack[`BIT_LASER_OFF] = (state_reg.ack[`BIT_LASER_OFF] | rise[`BIT_LASER_OFF])
        & cmd_used[`BIT_LASER_OFF] & (laser_switch_mode == `LSW_COMMAND);
      state_next.ack[`BIT_LASER_ON] = (state_reg.ack[`BIT_LASER_ON]
        | (rise[`BIT_LASER_ON] & ~rise[`BIT_LASER_OFF]))
        & cmd_used[`BIT_LASER_ON] & (laser_switch_mode == `LSW_COMMAND);
      state_next.ack[`BIT_ADJUST] = cmd_used[`BIT_ADJUST];
      state_next.ack[`BIT_PRESET] = cmd_used[`BIT_PRESET];
      state_next.ack[`BIT_PRESET_CLR] = cmd_used[`BIT_PRESET_CLR];
      state_next.ack[`BIT_ERR_CLR] = (state_reg.ack[`BIT_ERR_CLR]
        | (rise[`BIT_ERR_CLR] & (state_reg.policy == `POLICY_MANUAL)))
        & cmd_used[`BIT_ERR_CLR];
    end
    case (laser_switch_mode)
      `LSW_EXT_INPUT: state_next.laser_en = external_laser_switch_input;
      `LSW_AUTO: state_next.laser_en = auto_laser_request;
      default: state_next.laser_en = state_next.laser_cmd;
    endcase
    state_next.position = raw_position + state_reg.offset;
    // ----------------------------------------
    // error report
    // ----------------------------------------
    if (state_reg.policy == `POLICY_AUTO)
      state_next.error = fault_present;
    else if (data_valid && rise[`BIT_ERR_CLR])
      state_next.error = 1'b0;
    else if (fault_present)
      state_next.error = 1'b1;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= '0;
      state_reg.state <= ST_IDLE;
      state_reg.policy <= `POLICY_RESET;
    end
    else
      state_reg <= state_next;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign acknowledge_byte = state_reg.ack;
  assign laser_hours_word = state_reg.hours;
  assign laser_enable = state_reg.laser_en;
  assign position_out = state_reg.position;
  assign error_report = state_reg.error;
  assign cfg_id_cmd_ack = `CFG_ID_CMD_ACK;
  assign cfg_id_hours = `CFG_ID_HOURS;
endmodule
`default_nettype wire

// File: laser_command_ack_unit_chk.sv
`timescale 1ns/1ns
`default_nettype none
module laser_command_ack_unit_chk
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // master side
  input wire logic [7:0] command_byte,
  input wire logic data_valid,
  input wire logic [1:0] laser_switch_mode,
  input wire logic fault_present,
  input wire logic [31:0] adjust_value,
  // device side
  input wire logic [7:0] acknowledge_byte,
  input wire logic laser_enable,
  input wire logic [31:0] position_out,
  input wire logic error_report
);
  logic [7:0] prv_reg;
  logic [7:0] rise;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // last command seen in a valid frame
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
      prv_reg <= 8'h00;
    else if (data_valid)
      prv_reg <= command_byte;
  assign rise = data_valid ? (command_byte & ~prv_reg) : 8'h00;
  sequence s_adj;
    rise[4] && !rise[6];
  endsequence
  sequence s_pos;
    acknowledge_byte[4] ##1 position_out == adjust_value;
  endsequence
  property p_adj;
    s_adj |=> s_pos;
  endproperty
  a_adj: assert property (p_adj) else $error("adjust not applied");
  property p_unused;
    acknowledge_byte[3:2] == 2'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused ack bit set");
  property p_on;
    rise[1] && !command_byte[0] && laser_switch_mode == 2'h0 |=> laser_enable && acknowledge_byte[1];
  endproperty
  a_on: assert property (p_on) else $error("laser on failed");
  property p_off;
    rise[0] && laser_switch_mode == 2'h0 |=> !laser_enable && acknowledge_byte[0];
  endproperty
  a_off: assert property (p_off) else $error("laser off failed");
  property p_refuse;
    rise[1] && laser_switch_mode != 2'h0 |=> !acknowledge_byte[1];
  endproperty
  a_refuse: assert property (p_refuse) else $error("on acked in wrong mode");
  property p_drop;
    data_valid |=> (acknowledge_byte & ~$past(command_byte)) == 8'h00;
  endproperty
  a_drop: assert property (p_drop) else $error("ack without command");
  property p_hold;
    data_valid && command_byte[1] && acknowledge_byte[1] |=> acknowledge_byte[1];
  endproperty
  a_hold: assert property (p_hold) else $error("ack not held");
  property p_fault;
    fault_present && !rise[7] |=> error_report;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not reported");
endmodule
`default_nettype wire

// File: laser_command_ack_unit_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module laser_command_ack_unit_tb_top;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic prm_write = 1'b0;
  logic fault = 1'b0;
  logic ext_sw = 1'b0;
  logic auto_req = 1'b0;
  logic err_take;
  logic data_valid, laser_enable, error_report;
  logic [1:0] mode = 2'h0;
  logic [7:0] next_cmd = 8'h00;
  logic [7:0] policy = 8'h00;
  logic [7:0] command_byte, acknowledge_byte, c, id_a, id_h;
  logic [15:0] laser_hours_word, h0;
  logic [31:0] seed = 32'hE3B2;
  logic [31:0] adj, pre, raw, position_out;
  int n_errors = 0;
  int tests_run = 0;
  logic [7:0] q[$];
  always #20 clk_sys = ~clk_sys;
  fieldbus_master_model i_fieldbus_master_model (.clk_sys, .reset, .next_cmd, .command_byte,
    .data_valid);
  laser_command_ack_unit #(.CYCLES_PER_HOUR(40'hA)) i_laser_command_ack_unit (.clk_sys, .reset,
    .command_byte, .adjust_value(adj), .data_valid, .error_clear_policy(policy), .prm_write,
    .laser_switch_mode(mode), .preset_value(pre), .external_laser_switch_input(ext_sw),
    .auto_laser_request(auto_req), .raw_position(raw), .fault_present(fault), .acknowledge_byte,
    .laser_hours_word, .cfg_id_cmd_ack(id_a), .cfg_id_hours(id_h), .laser_enable,
    .position_out, .error_report);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // send one command frame and note the ack it must earn
  task automatic frame(input logic [7:0] cmd, input logic [7:0] e);
    int i;
    next_cmd = cmd;
    for (i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      if (data_valid && command_byte === cmd)
        break;
    end
    if (i == 8)
    begin
      n_errors++;
      summarize();
    end
    q.push_back(e);
    // error flag as it stands right after the taking edge
    #1;
    err_take = error_report;
    tick(1);
  endtask
  always @(posedge clk_sys)
    if (data_valid && !reset)
    begin
      @(posedge clk_sys);
      #1;
      if (q.size() > 0)
        chk(acknowledge_byte, q.pop_front());
    end
  initial
  begin
    adj = rnd();
    pre = rnd();
    raw = rnd();
    tick(10);
    reset = 1'b0;
    chk({id_a, id_h}, 32'h30D0);
    frame(8'h02, 8'h02);
    chk(laser_enable, 1'b1);
    frame(8'h02, 8'h02);
    tick(60);
    h0 = laser_hours_word;
    chk(h0 == 16'h5 || h0 == 16'h6, 1'b1);
    frame(8'h01, 8'h01);
    chk(laser_enable, 1'b0);
    h0 = laser_hours_word;
    frame(8'h00, 8'h00);
    tick(30);
    chk(laser_hours_word, h0);
    mode = 2'h1;
    frame(8'h02, 8'h00);
    chk(laser_enable, 1'b0);
    ext_sw = 1'b1;
    tick(1);
    chk(laser_enable, 1'b1);
    mode = 2'h2;
    ext_sw = 1'b0;
    auto_req = 1'b1;
    frame(8'h01, 8'h00);
    chk(laser_enable, 1'b1);
    auto_req = 1'b0;
    mode = 2'h0;
    frame(8'h0C, 8'h00);
    $display("laser test done");
    for (int k = 0; k < 3; k++)
    begin
      c = 8'h10 << k;
      frame(c, c);
      tick(1);
      chk(position_out, k == 0 ? adj : (k == 1 ? pre : raw));
    end
    frame(8'h00, 8'h00);
    $display("position test done");
    fault = 1'b1;
    tick(2);
    fault = 1'b0;
    tick(2);
    chk(error_report, 1'b1);
    frame(8'h80, 8'h80);
    chk(error_report, 1'b0);
    fault = 1'b1;
    frame(8'h00, 8'h00);
    frame(8'h80, 8'h80);
    chk(err_take, 1'b0);
    tick(1);
    chk(error_report, 1'b1);
    fault = 1'b0;
    policy = 8'h01;
    prm_write = 1'b1;
    tick(1);
    prm_write = 1'b0;
    frame(8'h00, 8'h00);
    frame(8'h80, 8'h00);
    chk(error_report, 1'b0);
    $display("error test done");
    summarize();
  end
endmodule
bind laser_command_ack_unit laser_command_ack_unit_chk i_laser_command_ack_unit_chk (.clk_sys,
  .reset, .command_byte, .data_valid, .laser_switch_mode, .fault_present, .adjust_value,
  .acknowledge_byte, .laser_enable, .position_out, .error_report);
`default_nettype wire
